// >>> package_idle_and_dram_power_ctrl.sv
// package idle resolution, regulator indicators and dram power control
// Behaviour
// - package request is lowest core state
// - any core c0 or no permission: c0
// - all cores c1 or deeper: package c1
// - c1e lowers clock first, then voltage
// - c1e on hint, limit, or auto-promotion
// - c1e enabled resolves c1-or-deeper to c1e; code does so only when the lowest core state is c1 or c1e
// - no system indication on c1/c1e entry
// - c3 when permitted or c6 not granted
// - shared cache snoopable in package c3
// - c6 only with all c6 and grant
// - stay c6 while shared cache active
// - deep-sleep indicator asserted in c6
// - four cke outputs, unpopulated ranks undriven
// - all ranks populated after reset
// - cke low until firmware config write
// - suspend: drain, self-refresh, cke low
// - internal graphics: self-refresh only when idle
// - external graphics: self-refresh with no requests
// - c0/c1/c1e: dynamic rank power-down
// - s3 self-refresh, s4 memory off
// - active or precharge power-down mode
// - power up all ranks around refresh
// - unused signals: driver, receiver, input gated
`timescale 1ns/100ps
`default_nettype none
module package_idle_and_dram_power_ctrl (
  // clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // axi4-lite write address and data
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // core idle states (3 bits per core) and hints, from core logic
  input wire logic [5:0] coreStates,
  input wire logic c1eHintAll,
  // platform permission inputs (asynchronous pins)
  input wire logic permitC3,
  input wire logic permitC6,
  input wire logic grantC6,
  // memory and graphics status from same-clock logic
  input wire logic cacheActive,
  input wire logic memRequestsPending,
  input wire logic gfxIdle,
  input wire logic displayPending,
  input wire logic rankIdle,
  input wire logic refreshRequest,
  input wire logic suspendRequest,
  input wire logic hibernateRequest,
  // package status and regulator indicators
  output logic [2:0] packageState,
  output logic cacheSnoopable,
  output logic lowFreqRequest,
  output logic lowVoltRequest,
  output logic power_status_indicator_n,
  output logic deep_sleep_regulator_n,
  output logic cstateNotify,
  // dram control
  output logic [3:0] ckeOut,
  output logic [3:0] ckeOe,
  output logic [3:0] chipSelOe,
  output logic [3:0] rxEnable,
  output logic prechargeAll,
  output logic refreshIssue,
  output logic memPowerOff
);
  typedef enum logic [2:0] {
    MEM_INIT,
    MEM_ACTIVE,
    MEM_PRECHARGE,
    MEM_POWERDOWN,
    MEM_REFRESH,
    MEM_DRAIN,
    MEM_SELFREF,
    MEM_OFF
  } mem_state_t;

  // registers
  logic [6:0] ctrl_reg;
  logic ckeRelease_reg;
  logic [3:0] present_reg;
  mem_state_t memState_reg;
  mem_state_t memState_next;
  logic [3:0] timer_reg;
  logic [3:0] timer_next;
  logic [1:0] c1eStep_reg;
  logic [2:0] pkgPrev_reg;
  // pin synchronisers
  logic [2:0] permSync1_reg;
  logic [2:0] permSync2_reg;
  // axi state
  logic awHeld_reg;
  logic wHeld_reg;
  logic [7:0] awAddr_reg;
  logic [31:0] wData_reg;
  logic [3:0] wStrb_reg;
  logic bValid_reg;
  logic bResp_reg;
  logic rValid_reg;
  logic [31:0] rData_reg;
  logic rResp_reg;
  // outputs from flops
  logic [3:0] cke_reg;
  logic [3:0] ckeOe_reg;
  logic precharge_reg;
  logic refresh_reg;
  logic memOff_reg;
  logic psi_reg;
  logic dprs_reg;
  logic snoop_reg;

  wire logic [2:0] pkgState;
  wire logic doWrite;
  wire logic writeHit;
  wire logic readHit;
  wire logic [31:0] readValue;
  wire logic inDeep;
  wire logic selfRefOk;
  wire logic idleLow;

  // permissions are pins from the platform, so two flops before use
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      permSync1_reg <= 3'h0;
      permSync2_reg <= 3'h0;
    end else begin
      permSync1_reg <= {grantC6, permitC6, permitC3};
      permSync2_reg <= permSync1_reg;
    end
  end

  idle_state_resolver i_idle_state_resolver (
    .mclk(mclk),
    .rstn(rstn),
    .coreStates(coreStates),
    .c1eEnable(ctrl_reg[pkg_idle_power::CTRL_C1E_EN]),
    .autoPromote(ctrl_reg[pkg_idle_power::CTRL_AUTOPROMO]),
    .limitToC1(ctrl_reg[pkg_idle_power::CTRL_LIMIT_C1]),
    .c1eHintAll(c1eHintAll),
    .permitC3(permSync2_reg[0]),
    .permitC6(permSync2_reg[1]),
    .grantC6(permSync2_reg[2]),
    .cacheActive(cacheActive),
    .pkgState(pkgState)
  );

  // axi decode
  assign doWrite = awHeld_reg && wHeld_reg && !bValid_reg;
  assign writeHit = (awAddr_reg == pkg_idle_power::ADDR_CTRL) ||
                    (awAddr_reg == pkg_idle_power::ADDR_CONFIG) ||
                    (awAddr_reg == pkg_idle_power::ADDR_PRESENT);
  assign readHit = (s_axi_araddr == pkg_idle_power::ADDR_CTRL) ||
                   (s_axi_araddr == pkg_idle_power::ADDR_CONFIG) ||
                   (s_axi_araddr == pkg_idle_power::ADDR_PRESENT) ||
                   (s_axi_araddr == pkg_idle_power::ADDR_STATUS);
  assign readValue =
    (s_axi_araddr == pkg_idle_power::ADDR_CTRL) ? {25'h0, ctrl_reg} :
    (s_axi_araddr == pkg_idle_power::ADDR_CONFIG) ? {31'h0, ckeRelease_reg} :
    (s_axi_araddr == pkg_idle_power::ADDR_PRESENT) ? {28'h0, present_reg} :
    (s_axi_araddr == pkg_idle_power::ADDR_STATUS) ?
      {24'h0, (memState_reg != MEM_INIT), pkgState, cke_reg} : 32'h0;

  // axi handshakes: address and data taken in either order
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      awHeld_reg <= 1'b0;
      wHeld_reg <= 1'b0;
      awAddr_reg <= 8'h00;
      wData_reg <= 32'h0;
      wStrb_reg <= 4'h0;
      bValid_reg <= 1'b0;
      bResp_reg <= 1'b0;
    end else begin
      if (s_axi_awvalid && !awHeld_reg) begin
        awHeld_reg <= 1'b1;
        awAddr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !wHeld_reg) begin
        wHeld_reg <= 1'b1;
        wData_reg <= s_axi_wdata;
        wStrb_reg <= s_axi_wstrb;
      end
      if (doWrite) begin
        bValid_reg <= 1'b1;
        bResp_reg <= !writeHit;
        awHeld_reg <= 1'b0;
        wHeld_reg <= 1'b0;
      end else if (bValid_reg && s_axi_bready) begin
        bValid_reg <= 1'b0;
      end
    end
  end

  // register writes; only the low byte holds live bits
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      ctrl_reg <= pkg_idle_power::CTRL_RESET;
      ckeRelease_reg <= 1'b0;
      present_reg <= pkg_idle_power::PRESENT_RESET;
    end else if (doWrite && wStrb_reg[0]) begin
      if (awAddr_reg == pkg_idle_power::ADDR_CTRL) begin
        ctrl_reg <= wData_reg[pkg_idle_power::CTRL_WIDTH-1:0];
      end
      if (awAddr_reg == pkg_idle_power::ADDR_CONFIG) begin
        ckeRelease_reg <= wData_reg[pkg_idle_power::CONFIG_CKE_RELEASE];
      end
      if (awAddr_reg == pkg_idle_power::ADDR_PRESENT) begin
        present_reg <= wData_reg[3:0];
      end
    end
  end

  // reads answer one cycle after the address is taken
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rValid_reg <= 1'b0;
      rData_reg <= 32'h0;
      rResp_reg <= 1'b0;
    end else if (s_axi_arvalid && !rValid_reg) begin
      rValid_reg <= 1'b1;
      rData_reg <= readValue;
      rResp_reg <= !readHit;
    end else if (rValid_reg && s_axi_rready) begin
      rValid_reg <= 1'b0;
    end
  end

  // memory power decisions
  assign inDeep = (pkgState == 3'(pkg_idle_power::CST_C3)) ||
                  (pkgState == 3'(pkg_idle_power::CST_C6));
  assign selfRefOk = ctrl_reg[pkg_idle_power::CTRL_INT_GFX] ?
    (gfxIdle && !displayPending && ctrl_reg[pkg_idle_power::CTRL_SINGLE_DISP])
    : !memRequestsPending;
  assign idleLow = ctrl_reg[pkg_idle_power::CTRL_DPD_EN] && rankIdle;

  // dram power state machine
  always_comb begin
    memState_next = memState_reg;
    timer_next = (timer_reg != 4'h0) ? timer_reg - 4'h1 : 4'h0;
    case (memState_reg)
      MEM_INIT: begin
        if (ckeRelease_reg) memState_next = MEM_ACTIVE;
      end
      MEM_ACTIVE: begin
        if (hibernateRequest) begin
          memState_next = MEM_OFF;
        end else if (suspendRequest || (inDeep && selfRefOk)) begin
          memState_next = MEM_DRAIN;
        end else if (idleLow && !refreshRequest) begin
          if (ctrl_reg[pkg_idle_power::CTRL_PRECHARGE_PD]) begin
            memState_next = MEM_PRECHARGE;
            timer_next = pkg_idle_power::PRECHARGE_CYCLES;
          end else begin
            memState_next = MEM_POWERDOWN;
          end
        end
      end
      MEM_PRECHARGE: begin
        if (timer_reg == 4'h0) memState_next = MEM_POWERDOWN;
      end
      MEM_POWERDOWN: begin
        if (refreshRequest) begin
          memState_next = MEM_REFRESH;
          timer_next = pkg_idle_power::REFRESH_CYCLES;
        end else if (!rankIdle || suspendRequest || hibernateRequest ||
                     (inDeep && selfRefOk)) begin
          memState_next = MEM_ACTIVE;
        end
      end
      MEM_REFRESH: begin
        if (timer_reg == 4'h0) begin
          memState_next = idleLow ? MEM_POWERDOWN : MEM_ACTIVE;
        end
      end
      MEM_DRAIN: begin
        if (!memRequestsPending) memState_next = MEM_SELFREF;
      end
      MEM_SELFREF: begin
        if (!suspendRequest && !(inDeep && selfRefOk)) memState_next = MEM_ACTIVE;
      end
      MEM_OFF: begin
        if (!hibernateRequest) memState_next = MEM_INIT;
      end
      default: memState_next = MEM_INIT;
    endcase
  end

  // dram state and pin flops; cke only rises on populated ranks
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      memState_reg <= MEM_INIT;
      timer_reg <= 4'h0;
      cke_reg <= 4'h0;
      ckeOe_reg <= 4'hF;
      precharge_reg <= 1'b0;
      refresh_reg <= 1'b0;
      memOff_reg <= 1'b0;
    end else begin
      memState_reg <= memState_next;
      timer_reg <= timer_next;
      ckeOe_reg <= present_reg;
      cke_reg <= ((memState_next == MEM_ACTIVE) || (memState_next == MEM_REFRESH) ||
                  (memState_next == MEM_PRECHARGE) || (memState_next == MEM_DRAIN))
                 ? present_reg : 4'h0;
      precharge_reg <= (memState_next == MEM_PRECHARGE);
      refresh_reg <= (memState_next == MEM_REFRESH);
      memOff_reg <= (memState_next == MEM_OFF);
    end
  end

  // package-level indicators and c1e frequency-then-voltage sequence
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      c1eStep_reg <= 2'h0;
      pkgPrev_reg <= 3'h0;
      psi_reg <= 1'b1;
      dprs_reg <= 1'b1;
      snoop_reg <= 1'b1;
    end else begin
      pkgPrev_reg <= pkgState;
      if (pkgState == 3'(pkg_idle_power::CST_C1E)) begin
        c1eStep_reg <= (c1eStep_reg == 2'h2) ? 2'h2 : c1eStep_reg + 2'h1;
      end else begin
        c1eStep_reg <= 2'h0;
      end
      psi_reg <= (pkgState == 3'(pkg_idle_power::CST_C0));
      dprs_reg <= (pkgState != 3'(pkg_idle_power::CST_C6));
      snoop_reg <= 1'b1;
    end
  end

  // outputs
  assign packageState = pkgPrev_reg;
  assign lowFreqRequest = (c1eStep_reg != 2'h0);
  assign lowVoltRequest = (c1eStep_reg == 2'h2);
  assign power_status_indicator_n = psi_reg;
  assign deep_sleep_regulator_n = dprs_reg;
  assign cacheSnoopable = snoop_reg;
  assign cstateNotify = 1'b0;
  assign ckeOut = cke_reg;
  assign ckeOe = ckeOe_reg;
  assign chipSelOe = ckeOe_reg;
  assign rxEnable = ckeOe_reg;
  assign prechargeAll = precharge_reg;
  assign refreshIssue = refresh_reg;
  assign memPowerOff = memOff_reg;
  assign s_axi_awready = !awHeld_reg;
  assign s_axi_wready = !wHeld_reg;
  assign s_axi_bvalid = bValid_reg;
  assign s_axi_bresp = bResp_reg ? pkg_idle_power::RESP_SLVERR : pkg_idle_power::RESP_OKAY;
  assign s_axi_arready = !rValid_reg;
  assign s_axi_rvalid = rValid_reg;
  assign s_axi_rdata = rData_reg;
  assign s_axi_rresp = rResp_reg ? pkg_idle_power::RESP_SLVERR : pkg_idle_power::RESP_OKAY;
endmodule
`default_nettype wire

// >>> pkg_idle_power.sv
// shared constants and types for the package idle and dram power block
package pkg_idle_power;
  // core and package idle states, numeric order matters
  typedef enum logic [2:0] {
    CST_C0 = 3'h0,
    CST_C1 = 3'h1,
    CST_C1E = 3'h2,
    CST_C3 = 3'h3,
    CST_C6 = 3'h4
  } cstate_t;

  localparam int NUM_CORES = 2;
  localparam int NUM_RANKS = 4;

  // axi register map (byte addresses)
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_CONFIG = 8'h04;
  localparam logic [7:0] ADDR_PRESENT = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0C;

  // control register fields
  localparam int CTRL_C1E_EN = 0;
  localparam int CTRL_AUTOPROMO = 1;
  localparam int CTRL_LIMIT_C1 = 2;
  localparam int CTRL_DPD_EN = 3;
  localparam int CTRL_PRECHARGE_PD = 4;
  localparam int CTRL_INT_GFX = 5;
  localparam int CTRL_SINGLE_DISP = 6;
  localparam int CTRL_WIDTH = 7;
  localparam logic [6:0] CTRL_RESET = 7'h08;

  // config register: bit 0 lets clock-enable rise after init
  localparam int CONFIG_CKE_RELEASE = 0;

  // presence register resets to all ranks populated
  localparam logic [3:0] PRESENT_RESET = 4'hF;

  // ddr3 init idle time and derived cycle count at 10 MHz
  localparam int CKE_INIT_US = 200;
  localparam int MCLK_MHZ = 10;
  localparam int CKE_INIT_CYCLES = CKE_INIT_US * MCLK_MHZ;

  // fsm timing: precharge and refresh windows in cycles
  localparam logic [3:0] PRECHARGE_CYCLES = 4'h4;
  localparam logic [3:0] REFRESH_CYCLES = 4'h8;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// >>> idle_state_resolver.sv
// combinational-to-registered resolver for the package idle state
`timescale 1ns/100ps
`default_nettype none
module idle_state_resolver (
  // clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // per-core states and configuration
  input wire logic [5:0] coreStates,
  input wire logic c1eEnable,
  input wire logic autoPromote,
  input wire logic limitToC1,
  input wire logic c1eHintAll,
  // platform permissions
  input wire logic permitC3,
  input wire logic permitC6,
  input wire logic grantC6,
  input wire logic cacheActive,
  // resolved state
  output logic [2:0] pkgState
);
  logic [2:0] pkgState_reg;
  logic [2:0] pkgState_next;
  logic [2:0] lowest;
  logic [2:0] stC0;
  logic [2:0] stC1;
  logic bothShallow;

  function automatic logic [2:0] minState(input logic [2:0] a, input logic [2:0] b);
    minState = (a < b) ? a : b;
  endfunction

  assign lowest = minState(coreStates[2:0], coreStates[5:3]);

  // c1 or c1e choice, depending on enable, hints and promotion
  assign bothShallow = (coreStates[2:0] < 3'(pkg_idle_power::CST_C3)) &&
                       (coreStates[5:3] < 3'(pkg_idle_power::CST_C3));
  assign stC1 = (c1eEnable || ((c1eHintAll || autoPromote) && bothShallow))
                ? 3'(pkg_idle_power::CST_C1E)
                : 3'(pkg_idle_power::CST_C1);
  assign stC0 = 3'(pkg_idle_power::CST_C0);

  // resolve: any c0, or c3-or-deeper with no permission, keeps package in c0; c1 limit gives c1e and c6 hold keeps c6
  always_comb begin
    pkgState_next = stC0;
    if (lowest == 3'(pkg_idle_power::CST_C0)) begin
      pkgState_next = stC0;
    end else if (lowest <= 3'(pkg_idle_power::CST_C1E)) begin
      pkgState_next = stC1;
    end else if (limitToC1) begin
      pkgState_next = 3'(pkg_idle_power::CST_C1E);
    end else if (lowest == 3'(pkg_idle_power::CST_C6) && permitC6 && grantC6) begin
      pkgState_next = 3'(pkg_idle_power::CST_C6);
    end else if (permitC3 || permitC6) begin
      pkgState_next = 3'(pkg_idle_power::CST_C3);
    end else begin
      pkgState_next = stC0;
    end
    // hold c6 while any shared cache part is active
    if (pkgState_reg == 3'(pkg_idle_power::CST_C6) && cacheActive &&
        lowest == 3'(pkg_idle_power::CST_C6)) begin
      pkgState_next = 3'(pkg_idle_power::CST_C6);
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      pkgState_reg <= 3'h0;
    end else begin
      pkgState_reg <= pkgState_next;
    end
  end

  assign pkgState = pkgState_reg;
endmodule
`default_nettype wire

// >>> idle_power_asserts.sv
// concurrent checks for the package idle and dram power block
`timescale 1ns/100ps
`default_nettype none
module idle_power_asserts (
  // clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // idle state inputs and outputs
  input wire logic [5:0] coreStates,
  input wire logic cacheActive,
  input wire logic [2:0] packageState,
  input wire logic cacheSnoopable,
  input wire logic lowFreqRequest,
  input wire logic lowVoltRequest,
  input wire logic deep_sleep_regulator_n,
  input wire logic cstateNotify,
  // dram outputs
  input wire logic [3:0] ckeOut,
  input wire logic [3:0] ckeOe,
  input wire logic [3:0] chipSelOe,
  input wire logic [3:0] rxEnable,
  input wire logic refreshIssue
);
  default clocking @(posedge mclk);
  endclocking
  default disable iff (!rstn);

  // three cycles cover the resolver and output registers
  sequence s_core_run;
    (coreStates[2:0] == 3'h0 || coreStates[5:3] == 3'h0) [*3];
  endsequence
  sequence s_not_all_c6;
    ((coreStates[2:0] != 3'h4 || coreStates[5:3] != 3'h4) && !cacheActive) [*3];
  endsequence
  sequence s_in_c6;
    (packageState == 3'h4) [*2];
  endsequence

  a_run_forces_c0: assert property (s_core_run |-> packageState == 3'h0)
    else $error("package left c0 with a core running");
  a_c6_all_cores: assert property (s_not_all_c6 |-> packageState != 3'h4)
    else $error("package c6 without all cores in c6");
  a_dsr_in_c6: assert property (s_in_c6 |-> !deep_sleep_regulator_n)
    else $error("deep sleep indicator not asserted in c6");
  a_dsr_outside_c6: assert property ((packageState != 3'h4) [*2] |-> deep_sleep_regulator_n)
    else $error("deep sleep indicator asserted outside c6");
  a_no_notify: assert property (cstateNotify == 1'b0)
    else $error("system notification raised");
  a_snoop_deep: assert property (packageState inside {3'h3, 3'h4} |-> cacheSnoopable)
    else $error("shared cache not snoopable in c3 or c6");
  a_volt_after_freq: assert property ($rose(lowVoltRequest) |-> $past(lowFreqRequest))
    else $error("voltage dropped before frequency");
  a_freq_held: assert property (lowVoltRequest |-> lowFreqRequest)
    else $error("low voltage without low frequency");
  a_unused_off: assert property (chipSelOe == ckeOe && rxEnable == ckeOe)
    else $error("select or receiver enable differs from presence");
  a_refresh_up: assert property (refreshIssue |-> (ckeOut & ckeOe) == ckeOe)
    else $error("rank powered down during refresh");
  a_cke_reset_low: assert property ($rose(rstn) |-> ckeOut == 4'h0)
    else $error("clock enable high out of reset");
endmodule

bind package_idle_and_dram_power_ctrl idle_power_asserts i_idle_power_asserts (
  .mclk(mclk), .rstn(rstn), .coreStates(coreStates), .cacheActive(cacheActive),
  .packageState(packageState), .cacheSnoopable(cacheSnoopable),
  .lowFreqRequest(lowFreqRequest), .lowVoltRequest(lowVoltRequest),
  .deep_sleep_regulator_n(deep_sleep_regulator_n), .cstateNotify(cstateNotify),
  .ckeOut(ckeOut), .ckeOe(ckeOe), .chipSelOe(chipSelOe), .rxEnable(rxEnable),
  .refreshIssue(refreshIssue)
);
`default_nettype wire

// >>> platform_partner.sv
// platform power partner driving the package permission pins
`timescale 1ns/100ps
`default_nettype none
module platform_partner (
  // clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // wanted level (1 c3, 2 c6 allowed, 3 c6 granted) and speed
  input wire logic [1:0] grantLevel,
  input wire logic slow,
  // permission pins
  output logic permitC3,
  output logic permitC6,
  output logic grantC6
);
  logic [1:0] levelReg;
  logic [2:0] waitReg;

  // a slow platform lags a few cycles; pins change together so no mixed set shows
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      levelReg <= 2'h0;
      waitReg <= 3'h0;
    end else if (grantLevel == levelReg) begin
      waitReg <= 3'h0;
    end else if (!slow || waitReg == 3'h5) begin
      levelReg <= grantLevel;
      waitReg <= 3'h0;
    end else begin
      waitReg <= waitReg + 3'h1;
    end
  end

  // pins decode the held level
  assign permitC3 = levelReg == 2'h1;
  assign permitC6 = levelReg[1];
  assign grantC6 = levelReg == 2'h3;
endmodule
`default_nettype wire

// >>> package_idle_and_dram_power_ctrl_test.sv
// self-checking bench for the package idle and dram power block
`timescale 1ns/100ps
`default_nettype none
module package_idle_and_dram_power_ctrl_test;
  logic mclk, rstn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, c1eHintAll, permitC3, permitC6, grantC6, cacheActive;
  logic slow, memPend, gfxIdle, dispPend, rankIdle, refreshReq, suspendReq, hibernateReq;
  logic snoop, freqReq, voltReq, psiN, dsrN, notify, prechargeAll, refreshIssue, memOff;
  logic [1:0] bresp, rresp, r, grantLevel;
  logic [2:0] packageState;
  logic [3:0] ckeOut, ckeOe, csOe, rxEn;
  logic [5:0] coreStates;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, d;
  int seed = 32'h1A710EB3;
  int bad_count, total_checks, i;

  package_idle_and_dram_power_ctrl i_package_idle_and_dram_power_ctrl (
    .mclk(mclk), .rstn(rstn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .coreStates(coreStates), .c1eHintAll(c1eHintAll), .permitC3(permitC3),
    .permitC6(permitC6), .grantC6(grantC6), .cacheActive(cacheActive),
    .memRequestsPending(memPend), .gfxIdle(gfxIdle), .displayPending(dispPend),
    .rankIdle(rankIdle), .refreshRequest(refreshReq), .suspendRequest(suspendReq),
    .hibernateRequest(hibernateReq), .packageState(packageState),
    .cacheSnoopable(snoop), .lowFreqRequest(freqReq), .lowVoltRequest(voltReq),
    .power_status_indicator_n(psiN), .deep_sleep_regulator_n(dsrN),
    .cstateNotify(notify), .ckeOut(ckeOut), .ckeOe(ckeOe), .chipSelOe(csOe),
    .rxEnable(rxEn), .prechargeAll(prechargeAll), .refreshIssue(refreshIssue),
    .memPowerOff(memOff)
  );

  platform_partner i_platform_partner (
    .mclk(mclk), .rstn(rstn), .grantLevel(grantLevel), .slow(slow),
    .permitC3(permitC3), .permitC6(permitC6), .grantC6(grantC6)
  );

  // clock source
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic tmo();
    bad_count++;
    $display("CHECK FAILED at %0t: wait ran out", $time);
    stop_test();
  endtask

  task automatic chk(logic [31:0] got, logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  // write: address and data offered together, each dropped once taken
  task automatic axiWrite(logic [7:0] a, logic [31:0] v);
    int n;
    n = 0;
    @(posedge mclk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid && n < 50);
    bready <= 1'b0;
    r = bresp;
    if (n >= 50) tmo();
  endtask

  task automatic axiRead(logic [7:0] a);
    int n;
    n = 0;
    @(posedge mclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
      if (arready) arvalid <= 1'b0;
    end while (!rvalid && n < 50);
    rready <= 1'b0;
    d = rdata;
    r = rresp;
    if (n >= 50) tmo();
  endtask

  // bounded waits on the populated clock enables and the package state
  task automatic waitCke(logic [3:0] e);
    int n;
    for (n = 0; n < 60 && (ckeOut & ckeOe) !== e; n++) @(posedge mclk);
    chk(ckeOut & ckeOe, e);
  endtask

  task automatic waitPkg(logic [2:0] e);
    int n;
    for (n = 0; n < 40 && packageState !== e; n++) @(posedge mclk);
    chk(packageState, e);
  endtask

  // expected package state; deeper states need permission, limit caps at c1e
  function automatic logic [2:0] expPkg(logic [2:0] a, logic [2:0] b, logic h,
                                        logic [1:0] lv, logic [2:0] ct);
    logic [2:0] lo;
    lo = (a < b) ? a : b;
    if (lo == 3'h0) return 3'h0;
    if (lo < 3'h3) return (ct[0] || ((a < 3'h3 && b < 3'h3) && (h || ct[1]))) ? 3'h2 : 3'h1;
    if (ct[2]) return 3'h2;
    if (lv == 2'h0) return 3'h0;
    return (lo == 3'h4 && lv == 2'h3) ? 3'h4 : 3'h3;
  endfunction

  function automatic logic [2:0] pick(logic [1:0] x);
    return {1'b0, x} + {2'h0, x[1]};
  endfunction

  task automatic runCase(logic [2:0] a, logic [2:0] b, logic h, logic [1:0] lv,
                         logic [2:0] ct);
    logic [2:0] e;
    e = expPkg(a, b, h, lv, ct);
    axiWrite(8'h00, {25'h0, 4'h1, ct});
    coreStates <= {b, a};
    c1eHintAll <= h;
    grantLevel <= lv;
    slow <= a[0] ^ lv[0];
    repeat (12) @(posedge mclk);
    waitPkg(e);
    axiRead(8'h0C);
    chk(d[6:4], e);
    chk(dsrN, e != 3'h4);
    chk(psiN, e == 3'h0);
    chk({freqReq, voltReq}, {2{e == 3'h2}});
  endtask

  initial begin
    {rstn, awvalid, wvalid, bready, arvalid, rready, c1eHintAll, slow, cacheActive} = '0;
    {memPend, gfxIdle, dispPend, rankIdle, refreshReq, suspendReq, hibernateReq} = '0;
    {awaddr, araddr, wdata, coreStates, grantLevel} = '0;
    repeat (2) @(posedge mclk);
    chk(ckeOut, 4'h0);
    chk(ckeOe, 4'hF);
    rstn <= 1'b1;
    axiRead(8'h08);
    chk(d[3:0], 4'hF);
    axiRead(8'h40);
    chk(r, pkg_idle_power::RESP_SLVERR);
    repeat (30) @(posedge mclk);
    chk(ckeOut, 4'h0);
    $display("reset test done");
    axiWrite(8'h08, 32'h5);
    repeat (2) @(posedge mclk);
    chk({ckeOe, csOe, rxEn}, 12'h555);
    axiWrite(8'h04, 32'h1);
    waitCke(4'h5);
    rankIdle <= 1'b1;
    waitCke(4'h0);
    refreshReq <= 1'b1;
    waitCke(4'h5);
    chk(refreshIssue, 1'b1);
    refreshReq <= 1'b0;
    waitCke(4'h0);
    rankIdle <= 1'b0;
    axiWrite(8'h00, 32'h18);
    waitCke(4'h5);
    rankIdle <= 1'b1;
    for (i = 0; i < 40 && prechargeAll !== 1'b1; i++) @(posedge mclk);
    chk(prechargeAll, 1'b1);
    chk(ckeOut & ckeOe, 4'h5);
    waitCke(4'h0);
    rankIdle <= 1'b0;
    $display("dram power-down test done");
    runCase(3'h1, 3'h1, 1'b0, 2'h0, 3'h0);
    runCase(3'h2, 3'h2, 1'b1, 2'h0, 3'h0);
    runCase(3'h1, 3'h1, 1'b0, 2'h0, 3'h2);
    runCase(3'h3, 3'h4, 1'b0, 2'h1, 3'h4);
    runCase(3'h1, 3'h3, 1'b0, 2'h1, 3'h1);
    runCase(3'h4, 3'h4, 1'b0, 2'h2, 3'h0);
    runCase(3'h4, 3'h4, 1'b0, 2'h3, 3'h0);
    {cacheActive, grantLevel} <= 3'h6;
    repeat (20) @(posedge mclk);
    chk(packageState, 3'h4);
    cacheActive <= 1'b0;
    waitPkg(3'h3);
    runCase(3'h4, 3'h3, 1'b0, 2'h3, 3'h0);
    runCase(3'h4, 3'h4, 1'b0, 2'h0, 3'h0);
    for (i = 0; i < 40; i++) begin
      d = $random(seed);
      runCase(pick(d[1:0]), pick(d[3:2]), d[4], d[6:5], d[9:7]);
    end
    $display("idle state test done");
    runCase(3'h3, 3'h3, 1'b0, 2'h1, 3'h0);
    waitCke(4'h0);
    memPend <= 1'b1;
    waitCke(4'h5);
    axiWrite(8'h00, 32'h68);
    memPend <= 1'b0;
    waitCke(4'h5);
    gfxIdle <= 1'b1;
    waitCke(4'h0);
    dispPend <= 1'b1;
    waitCke(4'h5);
    $display("self-refresh test done");
    runCase(3'h0, 3'h0, 1'b0, 2'h0, 3'h0);
    memPend <= 1'b1;
    suspendReq <= 1'b1;
    repeat (10) @(posedge mclk);
    chk(ckeOut & ckeOe, 4'h5);
    memPend <= 1'b0;
    waitCke(4'h0);
    {suspendReq, hibernateReq} <= 2'h1;
    for (i = 0; i < 40 && memOff !== 1'b1; i++) @(posedge mclk);
    chk(memOff, 1'b1);
    $display("sleep state test done");
    stop_test();
  end
endmodule
`default_nettype wire
